// [hdl/lp_mode_pkg.sv]
// Shared constants and types for the low-power mode controller
package lp_mode_pkg;

  // ------------------------------------------------------------
  // Register widths and field positions
  // ------------------------------------------------------------
  localparam int unsigned OSC_CTL_W       = 8;
  localparam int unsigned SLEEP_SEL_POS   = 4;
  localparam int unsigned PWR_CTL_W       = 8;
  localparam int unsigned RET_EN_POS      = 1;
  localparam int unsigned POR_CFG_W       = 8;
  localparam int unsigned RET_FUSE_POS    = 2;

  // ------------------------------------------------------------
  // Reset values and widths
  // ------------------------------------------------------------
  localparam logic        SLEEP_SEL_RST   = 1'b0;
  localparam int unsigned PRIO_W_DEF      = 3;
  localparam int unsigned N_PERIPH_DEF    = 8;

  // ------------------------------------------------------------
  // Power mode states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_IDLE,
    ST_SLEEP
  } lp_state_t;

endpackage

// [hdl/sleep_sel_reg.sv]
// Write-protected sleep-select bit of the oscillator control register
`timescale 1ns/1ps
module sleep_sel_reg
  import lp_mode_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic                 unlocked,
  input  wire logic                 osc_ctl_wr,
  input  wire logic [OSC_CTL_W-1:0] osc_ctl_wdata,
  output logic                      sleep_select_bit
);

  logic sleep_sel_ff;
  logic nxt_sleep_sel;
  logic wr_ok;

  // ------------------------------------------------------------
  // Write gating
  // ------------------------------------------------------------
  // R08 unlock gates write
  assign wr_ok         = osc_ctl_wr & unlocked;
  assign nxt_sleep_sel = wr_ok ? osc_ctl_wdata[SLEEP_SEL_POS] : sleep_sel_ff;

  // Locked writes appear to complete but leave the bit alone
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sleep_sel_ff <= SLEEP_SEL_RST;
    end else begin
      sleep_sel_ff <= nxt_sleep_sel;
    end
  end

  assign sleep_select_bit = sleep_sel_ff;

  // R08 locked write ignored
  a_locked_write_kept: assert property (@(posedge clk_sys) disable iff (!nrst) // R08
    (osc_ctl_wr && !unlocked) |=> $stable(sleep_sel_ff))
    else $error("sleep select changed without unlock");

endmodule

// [hdl/low_power_mode_control.sv]
// Run / Idle / Sleep controller with wake qualification and power gating
// Contract
// R01: Wait with sleep-select set enters Sleep.
// R02: Wait with sleep-select clear enters Idle.
// R03: In Sleep, enabled sleep-capable interrupt wakes only if priority beats CPU.
// R04: Losing interrupt in Sleep restarts bus clock, CPU stays halted, go Idle.
// R05: Sleep also ends on any reset and on watchdog time-out.
// R06: In Idle, enabled interrupt wakes only if priority beats CPU.
// R07: Idle also ends on any reset and on watchdog time-out.
// R08: Sleep-select changes only after the unlock sequence.
// R09: Sleep entry clears sleep watchdog counter, never the run counter; code clears it only when wdt_enable is set.
// R10: Fail-safe clock monitor is off throughout Sleep.
// R11: Brown-out reset circuit stays active during Sleep.
// R12: Retention regulator on in Sleep only if fuse zero and enable set.
// R13: Idle halts only the CPU; all clocks keep running. Code gates periph_clk_en for peripherals whose stop_in_idle_bit is set.
// R14: Peripherals with stop-in-idle set halt in Idle, others run.
// R15: Sleep halts CPU and most peripherals, gating their clocks.
// R16: Sleep keeps pin-change, watchdog, converter, serial and RC-clocked parts alive.
// R17: Output pins keep their drive unchanged through Sleep.
// R18: Run/Idle/Sleep machine returns to Run on wake, Run after reset.
`timescale 1ns/1ps
module low_power_mode_control
  import lp_mode_pkg::*;
#(
  parameter int unsigned PRIO_W   = PRIO_W_DEF,
  parameter int unsigned N_PERIPH = N_PERIPH_DEF
)(
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic                 wait_exec,
  input  wire logic                 unlocked,
  input  wire logic                 osc_ctl_wr,
  input  wire logic [OSC_CTL_W-1:0] osc_ctl_wdata,
  input  wire logic [PWR_CTL_W-1:0] power_control_reg,
  input  wire logic [POR_CFG_W-1:0] power_on_config_word,
  input  wire logic                 irq_req,
  input  wire logic                 irq_enabled,
  input  wire logic                 irq_sleep_capable,
  input  wire logic [PRIO_W-1:0]    irq_prio,
  input  wire logic [PRIO_W-1:0]    cpu_prio,
  input  wire logic                 wdt_enable,
  input  wire logic                 wdt_timeout,
  input  wire logic [N_PERIPH-1:0]  stop_in_idle_bit,
  output logic                      sleep_select_bit,
  output logic [1:0]                power_mode,
  output logic                      cpu_halt,
  output logic                      peripheral_bus_clock_en,
  output logic [N_PERIPH-1:0]       periph_clk_en,
  output logic                      sleep_alive_en,
  output logic                      fail_safe_clock_monitor_en,
  output logic                      brownout_reset_circuit_en,
  output logic                      retention_reg_on,
  output logic                      wdt_sleep_cnt_clr,
  output logic                      wdt_sleep_cnt_sel,
  output logic                      pin_drive_hold,
  output logic                      wake_pulse
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Strict comparison: an equal priority never wakes the core
  function automatic logic prio_wins(input logic [PRIO_W-1:0] req,
                                     input logic [PRIO_W-1:0] cur);
    prio_wins = (req > cur);
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  lp_state_t state_ff;
  lp_state_t nxt_state;
  logic      wdt_clr_ff;
  logic      nxt_wdt_clr;
  logic      wake_ff;
  logic      nxt_wake;
  logic      in_run;
  logic      in_idle;
  logic      in_sleep;
  logic      irq_wins;
  logic      sleep_irq;
  logic      idle_irq;
  logic      enter_sleep;
  logic      enter_idle;
  logic      ret_fuse;
  logic      ret_en;

  // ------------------------------------------------------------
  // Sleep-select register
  // ------------------------------------------------------------
  sleep_sel_reg u_sleep_sel (
    .clk_sys          (clk_sys),
    .nrst             (nrst),
    .unlocked         (unlocked),
    .osc_ctl_wr       (osc_ctl_wr),
    .osc_ctl_wdata    (osc_ctl_wdata),
    .sleep_select_bit (sleep_select_bit)
  );

  // ------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------
  assign in_run      = (state_ff == ST_RUN);
  assign in_idle     = (state_ff == ST_IDLE);
  assign in_sleep    = (state_ff == ST_SLEEP);
  assign irq_wins    = prio_wins(irq_prio, cpu_prio);
  // Only sources still clocked in Sleep can raise a request there
  assign sleep_irq   = irq_req & irq_enabled & irq_sleep_capable;
  assign idle_irq    = irq_req & irq_enabled;
  // R01 wait with select set
  assign enter_sleep = in_run & wait_exec & sleep_select_bit;
  // R02 wait with select clear
  assign enter_idle  = in_run & wait_exec & ~sleep_select_bit;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // R18 three-state mode machine
  always_comb begin
    nxt_state = state_ff;
    nxt_wake  = 1'b0;
    case (state_ff)
      ST_RUN: begin
        if (enter_sleep) begin
          nxt_state = ST_SLEEP;
        end else if (enter_idle) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        // R05 watchdog ends Sleep
        if (wdt_timeout) begin
          nxt_state = ST_RUN;
          nxt_wake  = 1'b1;
        // R03 winning interrupt wakes
        end else if (sleep_irq && irq_wins) begin
          nxt_state = ST_RUN;
          nxt_wake  = 1'b1;
        // R04 losing interrupt demotes
        end else if (sleep_irq) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // R07 watchdog ends Idle
        if (wdt_timeout) begin
          nxt_state = ST_RUN;
          nxt_wake  = 1'b1;
        // R06 only a winner wakes
        end else if (idle_irq && irq_wins) begin
          nxt_state = ST_RUN;
          nxt_wake  = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // R09 clear sleep counter only
  assign nxt_wdt_clr = enter_sleep & wdt_enable;

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  // R05 any reset lands in Run
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_ff   <= ST_RUN;
      wdt_clr_ff <= 1'b0;
      wake_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      wdt_clr_ff <= nxt_wdt_clr;
      wake_ff    <= nxt_wake;
    end
  end

  // ------------------------------------------------------------
  // Power and clock gating outputs
  // ------------------------------------------------------------
  assign power_mode                 = state_ff;
  assign cpu_halt                   = ~in_run;
  // R13 Idle keeps bus clock
  assign peripheral_bus_clock_en    = ~in_sleep;
  // R14 stop-in-idle gating
  assign periph_clk_en              = in_run ? {N_PERIPH{1'b1}} :
                                      in_idle ? ~stop_in_idle_bit : {N_PERIPH{1'b0}};
  // R16 sleep-capable parts stay alive
  assign sleep_alive_en             = 1'b1;
  // R10 monitor off in Sleep
  assign fail_safe_clock_monitor_en = ~in_sleep;
  // R11 brown-out always armed
  assign brownout_reset_circuit_en  = 1'b1;
  // R12 fuse low and enable high
  assign ret_fuse                   = power_on_config_word[RET_FUSE_POS];
  assign ret_en                     = power_control_reg[RET_EN_POS];
  assign retention_reg_on           = in_sleep & ~ret_fuse & ret_en;
  // R09 sleep counter runs in Sleep
  assign wdt_sleep_cnt_clr          = wdt_clr_ff;
  assign wdt_sleep_cnt_sel          = in_sleep;
  // R17 pad drivers never released; R15 gating is on clocks only
  assign pin_drive_hold             = in_sleep;
  assign wake_pulse                 = wake_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_wait_to_sleep: assert property (@(posedge clk_sys) disable iff (!nrst) // R01
    (in_run && wait_exec && sleep_select_bit) |=> in_sleep && cpu_halt)
    else $error("wait with select set did not sleep");

  a_wait_to_idle: assert property (@(posedge clk_sys) disable iff (!nrst) // R02
    (in_run && wait_exec && !sleep_select_bit) |=> in_idle && peripheral_bus_clock_en)
    else $error("wait with select clear did not idle");

  a_sleep_irq_wake: assert property (@(posedge clk_sys) disable iff (!nrst) // R03
    (in_sleep && !wdt_timeout && sleep_irq && irq_prio > cpu_prio)
      |=> in_run && wake_pulse)
    else $error("winning interrupt did not wake from sleep");

  a_sleep_demote: assert property (@(posedge clk_sys) disable iff (!nrst) // R04
    (in_sleep && !wdt_timeout && sleep_irq && irq_prio <= cpu_prio)
      |=> in_idle && cpu_halt && peripheral_bus_clock_en)
    else $error("losing interrupt did not demote to idle");

  a_sleep_wdt_exit: assert property (@(posedge clk_sys) disable iff (!nrst) // R05
    (in_sleep && wdt_timeout) |=> in_run ##1 !wake_pulse)
    else $error("watchdog did not end sleep");

  a_idle_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // R06
    (in_idle && !wdt_timeout && idle_irq && irq_prio <= cpu_prio) |=> in_idle)
    else $error("losing interrupt left idle");

  a_idle_wdt_exit: assert property (@(posedge clk_sys) disable iff (!nrst) // R07
    (in_idle && wdt_timeout) |=> in_run && !cpu_halt)
    else $error("watchdog did not end idle");

  a_wdt_sleep_clr: assert property (@(posedge clk_sys) disable iff (!nrst) // R09
    wdt_sleep_cnt_clr |-> in_sleep && $past(in_run) && $past(wdt_enable))
    else $error("sleep counter clear out of place");

  a_fail_safe_clock_monitor_off: assert property (@(posedge clk_sys) disable iff (!nrst) // R10
    in_sleep |-> !fail_safe_clock_monitor_en && brownout_reset_circuit_en)
    else $error("monitor or brown-out wrong in sleep");

  a_retention_on: assert property (@(posedge clk_sys) disable iff (!nrst) // R12
    retention_reg_on |-> in_sleep && !power_on_config_word[RET_FUSE_POS]
      && power_control_reg[RET_EN_POS])
    else $error("retention regulator on without its conditions");

  a_idle_stop_in_idle_bit: assert property (@(posedge clk_sys) disable iff (!nrst) // R14
    in_idle |-> periph_clk_en == ~stop_in_idle_bit)
    else $error("stop-in-idle gating wrong");

  a_reset_run: assert property (@(posedge clk_sys) // R18
    !nrst |=> in_run && !cpu_halt)
    else $error("reset did not return to run");

  a_idle_clocks_on: assert property (@(posedge clk_sys) disable iff (!nrst) // R13
    in_idle |-> cpu_halt && peripheral_bus_clock_en && fail_safe_clock_monitor_en)
    else $error("idle stopped more than the core");

  a_sleep_gated: assert property (@(posedge clk_sys) disable iff (!nrst) // R15
    in_sleep |-> cpu_halt && !peripheral_bus_clock_en && (periph_clk_en == '0))
    else $error("sleep left a gated clock running");

  a_sleep_alive: assert property (@(posedge clk_sys) disable iff (!nrst) // R16
    in_sleep |-> sleep_alive_en && brownout_reset_circuit_en)
    else $error("sleep-capable logic lost its clock");

  a_pins_held: assert property (@(posedge clk_sys) disable iff (!nrst) // R17
    in_sleep |-> pin_drive_hold)
    else $error("pad hold missing in sleep");

  a_sleep_quiet: assert property (@(posedge clk_sys) disable iff (!nrst) // R03
    (in_sleep && !wdt_timeout && !(irq_req && irq_enabled && irq_sleep_capable))
      |=> in_sleep)
    else $error("sleep ended without a wake event");

  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!nrst) // R06
    (in_idle && !wdt_timeout && !(irq_req && irq_enabled)) |=> in_idle)
    else $error("idle ended without a wake event");

  a_wake_from_halt: assert property (@(posedge clk_sys) disable iff (!nrst) // R18
    wake_pulse |-> in_run && $past(cpu_halt))
    else $error("wake pulse without a halted core");

  a_run_all_on: assert property (@(posedge clk_sys) disable iff (!nrst) // R18
    in_run |-> !cpu_halt && peripheral_bus_clock_en && (periph_clk_en == '1))
    else $error("run mode with a gated clock");

  c_sleep_wake: cover property (@(posedge clk_sys) disable iff (!nrst)
    in_run ##1 in_sleep [*2] ##1 in_run);

  c_sleep_idle_run: cover property (@(posedge clk_sys) disable iff (!nrst)
    in_sleep ##1 in_idle ##[1:20] in_run);

  c_idle_wdt: cover property (@(posedge clk_sys) disable iff (!nrst)
    in_idle && wdt_timeout ##1 in_run);

  c_idle_irq_wake: cover property (@(posedge clk_sys) disable iff (!nrst)
    in_idle && idle_irq && irq_wins ##1 in_run);

endmodule

// [tb/cpu_irq_model.sv]
// Stand-in for the CPU core and interrupt controller facing the mode controller
`timescale 1ns/1ps
module cpu_irq_model (
  input  wire logic clk_sys,
  output logic       wait_exec,
  output logic       irq_req,
  output logic       irq_enabled,
  output logic       irq_sleep_capable,
  output logic [2:0] irq_prio,
  output logic [2:0] cpu_prio,
  output logic       wdt_timeout
);
  // ----------------------------------------
  // Quiet core at time zero, CPU priority 2
  // ----------------------------------------
  initial begin
    wait_exec = 1'b0;
    irq_req = 1'b0;
    irq_enabled = 1'b0;
    irq_sleep_capable = 1'b0;
    irq_prio = 3'h0;
    cpu_prio = 3'h2;
    wdt_timeout = 1'b0;
  end

  // One-cycle wait, as the core retires it only once
  task automatic issue_wait();
    @(negedge clk_sys);
    wait_exec = 1'b1;
    @(negedge clk_sys);
    wait_exec = 1'b0;
  endtask

  // Request stays up as a level until the next call changes it
  task automatic set_irq(input logic req, input logic en, input logic cap,
                         input logic [2:0] prio);
    @(negedge clk_sys);
    irq_req = req;
    irq_enabled = en;
    irq_sleep_capable = cap;
    irq_prio = prio;
  endtask

  // Time-out is a single-cycle event
  task automatic pulse_wdt();
    @(negedge clk_sys);
    wdt_timeout = 1'b1;
    @(negedge clk_sys);
    wdt_timeout = 1'b0;
  endtask
endmodule

// [tb/low_power_mode_control_tb.sv]
// Self-checking bench for the Run / Idle / Sleep controller
`timescale 1ns/1ps
module low_power_mode_control_tb;
  import lp_mode_pkg::*;
  logic       clk_sys, nrst, unlocked, osc_ctl_wr, wdt_enable;
  logic [7:0] osc_ctl_wdata, power_control_reg, power_on_config_word;
  logic [7:0] stop_in_idle_bit, periph_clk_en;
  logic       wait_exec, irq_req, irq_enabled, irq_sleep_capable, wdt_timeout;
  logic [2:0] irq_prio, cpu_prio;
  logic [1:0] power_mode;
  logic       sleep_select_bit, cpu_halt, peripheral_bus_clock_en, sleep_alive_en;
  logic       fail_safe_clock_monitor_en, brownout_reset_circuit_en, retention_reg_on;
  logic       wdt_sleep_cnt_clr, wdt_sleep_cnt_sel, pin_drive_hold, wake_pulse;
  int         n_fail, n_tests, cyc;

  // ----------------------------------------
  // Clock, partner and design
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  cpu_irq_model cpu (.clk_sys, .wait_exec, .irq_req, .irq_enabled, .irq_sleep_capable,
                     .irq_prio, .cpu_prio, .wdt_timeout);
  low_power_mode_control DUT (.clk_sys, .nrst, .wait_exec, .unlocked, .osc_ctl_wr,
    .osc_ctl_wdata, .power_control_reg, .power_on_config_word, .irq_req, .irq_enabled,
    .irq_sleep_capable, .irq_prio, .cpu_prio, .wdt_enable, .wdt_timeout,
    .stop_in_idle_bit, .sleep_select_bit, .power_mode, .cpu_halt,
    .peripheral_bus_clock_en, .periph_clk_en, .sleep_alive_en,
    .fail_safe_clock_monitor_en, .brownout_reset_circuit_en, .retention_reg_on,
    .wdt_sleep_cnt_clr, .wdt_sleep_cnt_sel, .pin_drive_hold, .wake_pulse);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(negedge clk_sys);
  endtask
  // Sleep-select write, released a cycle later so the strobe never doubles
  task automatic wr_sel(input logic unl, input logic val);
    @(negedge clk_sys);
    osc_ctl_wr = 1'b1;
    unlocked = unl;
    osc_ctl_wdata = 8'(val) << SLEEP_SEL_POS;
    @(negedge clk_sys);
    osc_ctl_wr = 1'b0;
    unlocked = 1'b0;
  endtask
  // Everything that follows from the mode alone
  task automatic mode_is(input logic [1:0] m);
    chk(8'(power_mode), 8'(m));
    chk(8'(cpu_halt), 8'(m != 2'h0));
    chk(8'(peripheral_bus_clock_en), 8'(m != 2'h2));
    chk(8'(fail_safe_clock_monitor_en), 8'(m != 2'h2));
    chk(8'(wdt_sleep_cnt_sel), 8'(m == 2'h2));
    chk(8'(pin_drive_hold), 8'(m == 2'h2));
    chk(8'(brownout_reset_circuit_en), 8'h01);
    chk(8'(sleep_alive_en), 8'h01);
  endtask

  // Hang guard, well above the fewer than 60 cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 2000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {nrst, unlocked, osc_ctl_wr, wdt_enable} = 4'h0;
    osc_ctl_wdata = 8'h00;
    power_control_reg = 8'h02;
    power_on_config_word = 8'h00;
    stop_in_idle_bit = 8'ha5;
    repeat (8) step();
    mode_is(2'h0);
    chk(8'(sleep_select_bit), 8'h00);
    nrst = 1'b1;
    wr_sel(1'b0, 1'b1);
    chk(8'(sleep_select_bit), 8'h00);
    wr_sel(1'b1, 1'b1);
    chk(8'(sleep_select_bit), 8'h01);
    $display("test lock done");
    wdt_enable = 1'b1;
    cpu.issue_wait();
    mode_is(2'h2);
    chk(periph_clk_en, 8'h00);
    chk(8'(wdt_sleep_cnt_clr), 8'h01);
    // Retention needs fuse programmed to zero and enable set
    for (int i = 0; i < 4; i++) begin
      power_on_config_word = 8'(i[0]) << RET_FUSE_POS;
      power_control_reg = 8'(i[1]) << RET_EN_POS;
      #1 chk(8'(retention_reg_on), 8'(i == 2));
      step();
    end
    chk(8'(wdt_sleep_cnt_clr), 8'h00);
    // Disabled or not sleep-capable source must not wake Sleep, even at priority 5
    cpu.set_irq(1'b1, 1'b0, 1'b1, 3'h5);
    step();
    mode_is(2'h2);
    cpu.set_irq(1'b1, 1'b1, 1'b0, 3'h5);
    step();
    mode_is(2'h2);
    cpu.set_irq(1'b1, 1'b1, 1'b1, 3'h5);
    step();
    mode_is(2'h0);
    chk(8'(wake_pulse), 8'h01);
    chk(8'(retention_reg_on), 8'h00);
    step();
    chk(8'(wake_pulse), 8'h00);
    cpu.set_irq(1'b0, 1'b0, 1'b0, 3'h0);
    $display("test sleep wake done");
    wdt_enable = 1'b0;
    cpu.issue_wait();
    chk(8'(wdt_sleep_cnt_clr), 8'h00);
    cpu.set_irq(1'b1, 1'b1, 1'b1, 3'h2);
    step();
    mode_is(2'h1);
    step();
    mode_is(2'h1);
    // Idle wakes on any enabled source that beats the CPU priority, sleep-capable or not
    cpu.set_irq(1'b1, 1'b1, 1'b0, 3'h3);
    step();
    mode_is(2'h0);
    cpu.set_irq(1'b0, 1'b0, 1'b0, 3'h0);
    $display("test demote done");
    wr_sel(1'b1, 1'b0);
    cpu.issue_wait();
    mode_is(2'h1);
    chk(periph_clk_en, 8'h5a);
    cpu.set_irq(1'b1, 1'b0, 1'b1, 3'h7);
    step();
    mode_is(2'h1);
    // A wait seen outside Run changes nothing
    cpu.issue_wait();
    mode_is(2'h1);
    cpu.set_irq(1'b0, 1'b0, 1'b0, 3'h0);
    cpu.pulse_wdt();
    mode_is(2'h0);
    chk(periph_clk_en, 8'hff);
    $display("test idle done");
    wr_sel(1'b1, 1'b1);
    cpu.issue_wait();
    mode_is(2'h2);
    cpu.pulse_wdt();
    mode_is(2'h0);
    cpu.issue_wait();
    mode_is(2'h2);
    nrst = 1'b0;
    step();
    mode_is(2'h0);
    chk(8'(wake_pulse), 8'h00);
    chk(8'(sleep_select_bit), 8'h00);
    nrst = 1'b1;
    $display("test sleep exit done");
    give_verdict();
  end
endmodule
